// ### core/field_reg.sv
`timescale 1ns/100ps
module field_reg #(
	parameter int              W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         ref_clk_in, // System clock
	input  wire logic         clr_in,     // Return to default
	input  wire logic         wr_in,      // Host write strobe for this field
	input  wire logic [W-1:0] wdata_in,   // Host write data
	output logic      [W-1:0] q_out       // Stored value
);
	logic [W-1:0] q_r;

	// Clear before write: loss of power beats any pending write
	always_ff @(posedge ref_clk_in) begin
		if (clr_in) begin
			q_r <= RST;
		end else if (wr_in) begin
			q_r <= wdata_in;
		end
	end

	assign q_out = q_r;
endmodule : field_reg

// ### core/pmu_regs_pkg.sv
package pmu_regs_pkg;
	// Register offsets on the byte-wide register port
	localparam logic [7:0] OFF_SYS_MON_CFG   = 8'h00;
	localparam logic [7:0] OFF_SYS_CTRL      = 8'h01;
	localparam logic [7:0] OFF_B1_PRIMARY    = 8'h20;
	localparam logic [7:0] OFF_B1_SECONDARY  = 8'h21;
	localparam logic [7:0] OFF_B1_CTRL       = 8'h22;

	// Field positions in system_monitor_config
	localparam int BIT_RESET_TIMER_SEL = 7;
	localparam int BIT_RESPONSE_SEL    = 6;
	localparam int BIT_SUPPLY_IRQ_EN   = 5;
	localparam int BIT_BELOW_FLAG      = 4;
	localparam int LEVEL_MSB           = 3;
	localparam int LEVEL_LSB           = 0;

	// Field positions in system_control
	localparam int BIT_MASTER_SHUTDOWN = 5;
	localparam int SPARE_MSB           = 3;
	localparam int SPARE_LSB           = 0;

	// Field positions in the voltage code registers and buck_one_control
	localparam int VCODE_MSB           = 5;
	localparam int VCODE_LSB           = 0;
	localparam int BIT_B1_ENABLE       = 7;
	localparam int BIT_B1_PHASE        = 6;
	localparam int BIT_B1_MODE         = 5;
	localparam int DELAY_MSB           = 4;
	localparam int DELAY_LSB           = 2;
	localparam int BIT_B1_FAULT_IRQ_EN = 1;
	localparam int BIT_B1_POWER_GOOD   = 0;

	// Field widths
	localparam int LEVEL_W = 4;
	localparam int SPARE_W = 4;
	localparam int VCODE_W = 6;
	localparam int DELAY_W = 3;

	// Reset values of the writable fields
	localparam logic [0:0]         RST_BIT   = 1'h0;
	localparam logic [LEVEL_W-1:0] RST_LEVEL = 4'h0;
	localparam logic [SPARE_W-1:0] RST_SPARE = 4'h0;
	localparam logic [VCODE_W-1:0] RST_VCODE = 6'h00;
	localparam logic [DELAY_W-1:0] RST_DELAY = 3'h0;

	// Answer for unmapped addresses and reserved bits
	localparam logic [7:0] RD_EMPTY = 8'h00;

	// System power state, one-hot
	typedef enum logic [1:0] {
		PWR_RUN = 2'b01,
		PWR_OFF = 2'b10
	} power_state_e;
endpackage : pmu_regs_pkg

// ### core/pmu_system_and_buck_one_regs.sv
`timescale 1ns/100ps
// How it works
// [RQ1] Bit 7 of 0x00 selects reset timeout
// [RQ2] Response bit 1: low supply raises interrupt
// [RQ3] Response bit 0: low supply shuts everything
// [RQ4] Supply interrupt only while its enable set
// [RQ5] Read-only flag shows supply below threshold
// [RQ6] Four-bit threshold level in 0x00 low bits
// [RQ7] Master shutdown bit turns all outputs off
// [RQ8] Pushbutton press clears master shutdown bit
// [RQ9] Spare bits writable, cleared on system shutdown
// [RQ10] Pin low selects primary voltage code
// [RQ11] Pin high selects secondary voltage code
// [RQ12] Enable bit turns first converter on/off
// [RQ13] Phase bit picks inverted or same phase
// [RQ14] Mode bit forces fixed frequency switching
// [RQ15] Three-bit turn-on delay field in 0x22
// [RQ16] Fault interrupt enable gates converter faults
// [RQ17] Bit 0 of 0x22 shows power good
// [RQ18] Power loss returns all bits to default
// [RQ19] Reserved bits read zero, writes ignored
module pmu_system_and_buck_one_regs (
	input  wire logic       ref_clk_in,              // 200 MHz system clock
	input  wire logic       rst_in,                  // Synchronous reset, active high
	input  wire logic       uvlo_in,                 // Input power lost, async
	input  wire logic [7:0] reg_addr_in,             // Register address
	input  wire logic       reg_wr_in,               // Write strobe, one cycle
	input  wire logic [7:0] reg_wdata_in,            // Write data
	input  wire logic       reg_rd_in,               // Read strobe, one cycle
	input  wire logic       supply_below_raw_in,     // Monitor comparator, async
	input  wire logic       power_good_raw_in,       // Converter power good, async
	input  wire logic       voltage_set_pin_in,      // Voltage select pin, async
	input  wire logic       pushbutton_input_n_in,   // Pushbutton, active low, async
	input  wire logic       buck_one_fault_raw_in,   // Converter fault, async
	output logic [7:0]      reg_rdata_out,           // Read data
	output logic            reg_rvalid_out,          // Read data valid, one cycle
	output logic            reset_timer_long_out,    // Reset timeout selection
	output logic [3:0]      threshold_level_out,     // Monitor threshold code
	output logic            supply_irq_out,          // Supply-low interrupt, level
	output logic            system_off_out,          // All regulators off
	output logic            buck_one_enable_out,     // First converter running
	output logic [5:0]      buck_one_vcode_out,      // Active voltage code
	output logic            buck_one_phase_inv_out,  // Run 180 degrees shifted
	output logic            buck_one_fixed_freq_out, // Fixed-frequency switching
	output logic [2:0]      buck_one_delay_out,      // Turn-on delay code
	output logic            buck_one_fault_irq_out   // Fault interrupt, level
);
	// Synchronised pin and analog levels
	logic uvlo_s;
	logic below_s;
	logic pgood_s;
	logic voltage_set_pin_s;
	logic pb_n_s;
	logic fault_s;
	logic clr_all;
	logic pb_pressed;

	// Write strobes per register
	logic wr_mon;
	logic wr_ctrl;
	logic wr_prim;
	logic wr_sec;
	logic wr_b1;

	// Stored fields
	logic                                 reset_timer_sel;
	logic                                 response_sel;
	logic                                 supply_irq_en;
	logic [pmu_regs_pkg::LEVEL_W-1:0]     level;
	logic                                 master_shutdown_r;
	logic                                 master_shutdown_nxt;
	logic [pmu_regs_pkg::SPARE_W-1:0]     spare;
	logic [pmu_regs_pkg::VCODE_W-1:0]     vcode_primary;
	logic [pmu_regs_pkg::VCODE_W-1:0]     vcode_secondary;
	logic                                 b1_enable;
	logic                                 b1_phase;
	logic                                 b1_mode;
	logic [pmu_regs_pkg::DELAY_W-1:0]     b1_delay;
	logic                                 b1_fault_en;

	// System state
	pmu_regs_pkg::power_state_e state_r;
	pmu_regs_pkg::power_state_e state_nxt;
	logic                       auto_off;
	logic                       shut_go;
	logic                       spare_clr;
	logic [7:0]                 rd_nxt;

	// Every asynchronous level passes two flops before use
	sync_two_flop #(.IDLE(1'b0)) u_sync_uvlo (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (uvlo_in),
		.sync_out   (uvlo_s)
	);
	sync_two_flop #(.IDLE(1'b0)) u_sync_below (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (supply_below_raw_in),
		.sync_out   (below_s)
	);
	sync_two_flop #(.IDLE(1'b0)) u_sync_pgood (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (power_good_raw_in),
		.sync_out   (pgood_s)
	);
	sync_two_flop #(.IDLE(1'b0)) u_sync_voltage_set_pin (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (voltage_set_pin_in),
		.sync_out   (voltage_set_pin_s)
	);
	sync_two_flop #(.IDLE(1'b1)) u_sync_pb (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (pushbutton_input_n_in),
		.sync_out   (pb_n_s)
	);
	sync_two_flop #(.IDLE(1'b0)) u_sync_fault (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (buck_one_fault_raw_in),
		.sync_out   (fault_s)
	);

	// Reset and power loss both return every bit to default
	assign clr_all    = rst_in | uvlo_s; // [RQ18]
	assign pb_pressed = ~pb_n_s;

	// Address decode; unmapped writes go nowhere
	assign wr_mon  = reg_wr_in && (reg_addr_in == pmu_regs_pkg::OFF_SYS_MON_CFG);
	assign wr_ctrl = reg_wr_in && (reg_addr_in == pmu_regs_pkg::OFF_SYS_CTRL);
	assign wr_prim = reg_wr_in && (reg_addr_in == pmu_regs_pkg::OFF_B1_PRIMARY);
	assign wr_sec  = reg_wr_in && (reg_addr_in == pmu_regs_pkg::OFF_B1_SECONDARY);
	assign wr_b1   = reg_wr_in && (reg_addr_in == pmu_regs_pkg::OFF_B1_CTRL);

	// System monitor configuration fields
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_reset_timer (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_mon),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_RESET_TIMER_SEL]),
		.q_out      (reset_timer_sel)
	);
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_response (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_mon),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_RESPONSE_SEL]),
		.q_out      (response_sel)
	);
	// Interrupt disabled out of reset
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_supply_irq_en (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_mon),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_SUPPLY_IRQ_EN]),
		.q_out      (supply_irq_en)
	);
	field_reg #(.W(pmu_regs_pkg::LEVEL_W), .RST(pmu_regs_pkg::RST_LEVEL)) u_level (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_mon),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::LEVEL_MSB:pmu_regs_pkg::LEVEL_LSB]), // [RQ6]
		.q_out      (level)
	);

	// Spare bits: storage only, wiped when the system goes off
	assign spare_clr = clr_all | shut_go; // [RQ9]
	field_reg #(.W(pmu_regs_pkg::SPARE_W), .RST(pmu_regs_pkg::RST_SPARE)) u_spare (
		.ref_clk_in (ref_clk_in),
		.clr_in     (spare_clr),
		.wr_in      (wr_ctrl),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::SPARE_MSB:pmu_regs_pkg::SPARE_LSB]),
		.q_out      (spare)
	);

	// Voltage codes; bits 7:6 are never stored
	field_reg #(.W(pmu_regs_pkg::VCODE_W), .RST(pmu_regs_pkg::RST_VCODE)) u_vcode_prim (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_prim),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::VCODE_MSB:pmu_regs_pkg::VCODE_LSB]), // [RQ19]
		.q_out      (vcode_primary)
	);
	field_reg #(.W(pmu_regs_pkg::VCODE_W), .RST(pmu_regs_pkg::RST_VCODE)) u_vcode_sec (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_sec),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::VCODE_MSB:pmu_regs_pkg::VCODE_LSB]), // [RQ19]
		.q_out      (vcode_secondary)
	);

	// Converter control fields; power-good bit is not writable
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_b1_enable (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_b1),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_B1_ENABLE]),
		.q_out      (b1_enable)
	);
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_b1_phase (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_b1),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_B1_PHASE]),
		.q_out      (b1_phase)
	);
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_b1_mode (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_b1),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_B1_MODE]),
		.q_out      (b1_mode)
	);
	field_reg #(.W(pmu_regs_pkg::DELAY_W), .RST(pmu_regs_pkg::RST_DELAY)) u_b1_delay (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_b1),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::DELAY_MSB:pmu_regs_pkg::DELAY_LSB]), // [RQ15]
		.q_out      (b1_delay)
	);
	field_reg #(.W(1), .RST(pmu_regs_pkg::RST_BIT)) u_b1_fault_en (
		.ref_clk_in (ref_clk_in),
		.clr_in     (clr_all),
		.wr_in      (wr_b1),
		.wdata_in   (reg_wdata_in[pmu_regs_pkg::BIT_B1_FAULT_IRQ_EN]),
		.q_out      (b1_fault_en)
	);

	// Master shutdown: pushbutton clear beats a same-cycle write
	always_comb begin
		master_shutdown_nxt = master_shutdown_r;
		if (wr_ctrl) begin
			master_shutdown_nxt = reg_wdata_in[pmu_regs_pkg::BIT_MASTER_SHUTDOWN];
		end
		if (pb_pressed) begin
			master_shutdown_nxt = 1'b0; // [RQ8]
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (clr_all) begin
			master_shutdown_r <= pmu_regs_pkg::RST_BIT;
		end else begin
			master_shutdown_r <= master_shutdown_nxt;
		end
	end

	// Low supply shuts down only when response select is 0
	assign auto_off = below_s && !response_sel; // [RQ3]
	assign shut_go  = (state_r == pmu_regs_pkg::PWR_RUN) && (master_shutdown_r || auto_off);

	// Power state; a press restarts, a standing low supply drops it again
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pmu_regs_pkg::PWR_RUN: begin
				if (shut_go) begin
					state_nxt = pmu_regs_pkg::PWR_OFF; // [RQ7] [RQ3]
				end
			end
			pmu_regs_pkg::PWR_OFF: begin
				if (pb_pressed) begin
					state_nxt = pmu_regs_pkg::PWR_RUN;
				end
			end
			default: begin
				state_nxt = pmu_regs_pkg::PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (clr_all) begin
			state_r <= pmu_regs_pkg::PWR_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Read mux; reserved bits and unmapped addresses read zero
	always_comb begin
		rd_nxt = pmu_regs_pkg::RD_EMPTY;
		case (reg_addr_in)
			pmu_regs_pkg::OFF_SYS_MON_CFG: begin
				rd_nxt[pmu_regs_pkg::BIT_RESET_TIMER_SEL] = reset_timer_sel;
				rd_nxt[pmu_regs_pkg::BIT_RESPONSE_SEL]    = response_sel;
				rd_nxt[pmu_regs_pkg::BIT_SUPPLY_IRQ_EN]   = supply_irq_en;
				rd_nxt[pmu_regs_pkg::BIT_BELOW_FLAG]      = below_s; // [RQ5]
				rd_nxt[pmu_regs_pkg::LEVEL_MSB:pmu_regs_pkg::LEVEL_LSB] = level;
			end
			pmu_regs_pkg::OFF_SYS_CTRL: begin
				rd_nxt[pmu_regs_pkg::BIT_MASTER_SHUTDOWN] = master_shutdown_r;
				rd_nxt[pmu_regs_pkg::SPARE_MSB:pmu_regs_pkg::SPARE_LSB] = spare; // [RQ19]
			end
			pmu_regs_pkg::OFF_B1_PRIMARY: begin
				rd_nxt[pmu_regs_pkg::VCODE_MSB:pmu_regs_pkg::VCODE_LSB] = vcode_primary;
			end
			pmu_regs_pkg::OFF_B1_SECONDARY: begin
				rd_nxt[pmu_regs_pkg::VCODE_MSB:pmu_regs_pkg::VCODE_LSB] = vcode_secondary;
			end
			pmu_regs_pkg::OFF_B1_CTRL: begin
				rd_nxt[pmu_regs_pkg::BIT_B1_ENABLE]       = b1_enable;
				rd_nxt[pmu_regs_pkg::BIT_B1_PHASE]        = b1_phase;
				rd_nxt[pmu_regs_pkg::BIT_B1_MODE]         = b1_mode;
				rd_nxt[pmu_regs_pkg::DELAY_MSB:pmu_regs_pkg::DELAY_LSB] = b1_delay;
				rd_nxt[pmu_regs_pkg::BIT_B1_FAULT_IRQ_EN] = b1_fault_en;
				rd_nxt[pmu_regs_pkg::BIT_B1_POWER_GOOD]   = pgood_s; // [RQ17]
			end
			default: begin
				rd_nxt = pmu_regs_pkg::RD_EMPTY;
			end
		endcase
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (clr_all) begin
			reg_rdata_out  <= pmu_regs_pkg::RD_EMPTY;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rd_nxt;
			end
		end
	end

	// System-level outputs, all registered
	always_ff @(posedge ref_clk_in) begin
		if (clr_all) begin
			reset_timer_long_out <= 1'b0;
			threshold_level_out  <= pmu_regs_pkg::RST_LEVEL;
			supply_irq_out       <= 1'b0;
			system_off_out       <= 1'b0;
		end else begin
			reset_timer_long_out <= reset_timer_sel; // [RQ1]
			threshold_level_out  <= level; // [RQ6]
			supply_irq_out       <= below_s && response_sel && supply_irq_en; // [RQ2] [RQ4]
			system_off_out       <= (state_nxt == pmu_regs_pkg::PWR_OFF); // [RQ7]
		end
	end

	// Converter outputs; off state overrides the enable bit
	always_ff @(posedge ref_clk_in) begin
		if (clr_all) begin
			buck_one_enable_out     <= 1'b0;
			buck_one_vcode_out      <= pmu_regs_pkg::RST_VCODE;
			buck_one_phase_inv_out  <= 1'b0;
			buck_one_fixed_freq_out <= 1'b0;
			buck_one_delay_out      <= pmu_regs_pkg::RST_DELAY;
			buck_one_fault_irq_out  <= 1'b0;
		end else begin
			buck_one_enable_out     <= b1_enable && (state_nxt == pmu_regs_pkg::PWR_RUN); // [RQ12]
			buck_one_vcode_out      <= voltage_set_pin_s ? vcode_secondary : vcode_primary; // [RQ10] [RQ11]
			buck_one_phase_inv_out  <= b1_phase; // [RQ13]
			buck_one_fixed_freq_out <= b1_mode; // [RQ14]
			buck_one_delay_out      <= b1_delay; // [RQ15]
			buck_one_fault_irq_out  <= fault_s && b1_fault_en; // [RQ16]
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (clr_all);

	a_vcode_select: assert property ( // [RQ10] [RQ11]
		1'b1 |=> buck_one_vcode_out == $past(voltage_set_pin_s ? vcode_secondary : vcode_primary))
		else $error("voltage code does not follow select pin");
	a_supply_irq_gate: assert property ( // [RQ2] [RQ4]
		supply_irq_out |-> $past(below_s && response_sel && supply_irq_en))
		else $error("supply interrupt without cause");
	a_auto_shutdown: assert property ( // [RQ3]
		(state_r == pmu_regs_pkg::PWR_RUN && auto_off) |=> system_off_out && !buck_one_enable_out)
		else $error("low supply did not shut down");
	a_irq_mode_runs: assert property ( // [RQ2]
		(state_r == pmu_regs_pkg::PWR_RUN && response_sel && !master_shutdown_r)
		|=> state_r == pmu_regs_pkg::PWR_RUN)
		else $error("interrupt mode shut down");
	a_master_off: assert property ( // [RQ7]
		(wr_ctrl && reg_wdata_in[pmu_regs_pkg::BIT_MASTER_SHUTDOWN] && !pb_pressed) ##1
		!pb_pressed |=> system_off_out)
		else $error("master shutdown ignored");
	a_pb_clears_master: assert property ( // [RQ8]
		pb_pressed |=> !master_shutdown_r)
		else $error("pushbutton did not clear master shutdown");
	a_spare_wipe: assert property ( // [RQ9]
		shut_go |=> spare == pmu_regs_pkg::RST_SPARE)
		else $error("spare bits survived shutdown");
	a_off_disables: assert property ( // [RQ12]
		system_off_out |-> !buck_one_enable_out)
		else $error("converter on while system off");
	a_reserved_zero: assert property ( // [RQ19]
		(reg_rd_in && reg_addr_in == pmu_regs_pkg::OFF_B1_PRIMARY) |=> reg_rdata_out[7:6] == 2'h0)
		else $error("reserved bits read nonzero");
	a_pgood_read: assert property ( // [RQ17]
		(reg_rd_in && reg_addr_in == pmu_regs_pkg::OFF_B1_CTRL)
		|=> reg_rdata_out[pmu_regs_pkg::BIT_B1_POWER_GOOD] == $past(pgood_s))
		else $error("power good bit wrong");
	a_below_flag: assert property ( // [RQ5]
		(reg_rd_in && reg_addr_in == pmu_regs_pkg::OFF_SYS_MON_CFG)
		|=> reg_rdata_out[pmu_regs_pkg::BIT_BELOW_FLAG] == $past(below_s))
		else $error("below flag wrong");
	a_level_out: assert property ( // [RQ6]
		wr_mon ##1 !wr_mon |=> threshold_level_out == $past(reg_wdata_in[3:0], 2))
		else $error("threshold level not applied");
endmodule : pmu_system_and_buck_one_regs

// ### core/sync_two_flop.sv
`timescale 1ns/100ps
module sync_two_flop #(
	parameter logic IDLE = 1'b0
) (
	input  wire logic ref_clk_in, // System clock
	input  wire logic rst_in,     // Synchronous reset, active high
	input  wire logic async_in,   // Signal from another domain
	output logic      sync_out    // Signal after two flops
);
	logic meta_r;
	logic sync_r;

	// First flop feeds only the second one
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_r <= IDLE;
			sync_r <= IDLE;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule : sync_two_flop

// ### dv/pmu_host_model.sv
`timescale 1ns/100ps
// Host side of the byte-wide register port, one-cycle strobes
module pmu_host_model (
	input  wire logic       ref_clk_in, // System clock
	input  wire logic [7:0] rdata_in,   // Read data from device
	input  wire logic       rvalid_in,  // Read data valid
	output logic      [7:0] addr_out,   // Register address
	output logic            wr_out,     // Write strobe
	output logic      [7:0] wdata_out,  // Write data
	output logic            rd_out      // Read strobe
);
	// Idle bus at time zero
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end

	// Released address and data flip, so stale values never pass for valid ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr_out  <= a;
		wdata_out <= d;
		wr_out    <= 1'b1;
		@(posedge ref_clk_in);
		wr_out    <= 1'b0;
		addr_out  <= ~a;
		wdata_out <= ~d;
	endtask : wr

	// Read, answer awaited for a bounded number of cycles
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		int n;
		@(posedge ref_clk_in);
		addr_out <= a;
		rd_out   <= 1'b1;
		@(posedge ref_clk_in);
		rd_out   <= 1'b0;
		addr_out <= ~a;
		ok = 1'b0;
		d = 8'h00;
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (rvalid_in === 1'b1) begin
				ok = 1'b1;
				d = rdata_in;
			end else begin
				@(posedge ref_clk_in);
			end
		end
		// Hand back on an edge, so the caller's pin changes stay edge-aligned
		@(posedge ref_clk_in);
	endtask : rd
endmodule : pmu_host_model

// ### dv/pmu_system_and_buck_one_regs_tb.sv
`timescale 1ns/100ps
module pmu_system_and_buck_one_regs_tb;
	logic       ref_clk, rst, uvlo, below, pg, vpin, pb_n, fault;
	logic [7:0] addr, wdata, rdata, mdl [0:4], v, d;
	logic       wr, rd, rvalid, t_long, s_irq, s_off, en, ph, ff, f_irq;
	logic [3:0] lvl;
	logic [5:0] vcode;
	logic [2:0] dly;
	bit         ok;
	int         error_cnt, tests_run, i, k;
	logic [7:0] addrs [0:4] = '{pmu_regs_pkg::OFF_SYS_MON_CFG, pmu_regs_pkg::OFF_SYS_CTRL,
		pmu_regs_pkg::OFF_B1_PRIMARY, pmu_regs_pkg::OFF_B1_SECONDARY, pmu_regs_pkg::OFF_B1_CTRL};

	pmu_system_and_buck_one_regs uut (.ref_clk_in(ref_clk), .rst_in(rst), .uvlo_in(uvlo),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
		.supply_below_raw_in(below), .power_good_raw_in(pg), .voltage_set_pin_in(vpin),
		.pushbutton_input_n_in(pb_n), .buck_one_fault_raw_in(fault), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .reset_timer_long_out(t_long), .threshold_level_out(lvl),
		.supply_irq_out(s_irq), .system_off_out(s_off), .buck_one_enable_out(en),
		.buck_one_vcode_out(vcode), .buck_one_phase_inv_out(ph), .buck_one_fixed_freq_out(ff),
		.buck_one_delay_out(dly), .buck_one_fault_irq_out(f_irq));
	pmu_host_model host (.ref_clk_in(ref_clk), .rdata_in(rdata), .rvalid_in(rvalid),
		.addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

	// Clock, 5 ns period
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Expected read value: reserved bits zero, status bits from the pins
	function automatic logic [7:0] model_rd(input int r);
		case (r)
			0: return (mdl[0] & 8'hEF) | {3'h0, below, 4'h0};
			1: return mdl[1] & 8'h2F;
			4: return (mdl[4] & 8'hFE) | {7'h00, pg};
			default: return mdl[r] & 8'h3F;
		endcase
	endfunction : model_rd

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Read one register and compare; a missing answer ends the run
	task automatic rdchk(input int r);
		host.rd(addrs[r], d, ok);
		if (!ok) begin
			error_cnt++;
			summarize();
		end
		chk(d, model_rd(r));
	endtask : rdchk

	task automatic wrm(input int r, input logic [7:0] val);
		host.wr(addrs[r], val);
		mdl[r] = val;
	endtask : wrm

	// Pins take two sync flops plus an output flop; five edges cover it
	task automatic settle();
		repeat (5) @(posedge ref_clk);
	endtask : settle

	// Hang guard
	initial begin
		repeat (50000) @(posedge ref_clk);
		error_cnt++;
		summarize();
	end

	initial begin
		{rst, uvlo, below, pg, vpin, fault} = 6'h20;
		pb_n = 1'b1;
		foreach (mdl[r]) mdl[r] = 8'h00;
		void'($urandom(32'hDDCC3B71));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 5; i++) rdchk(i);
		host.rd(8'h10, d, ok);
		chk(ok ? d : 8'hFF, 8'h00);
		// Random contents, master shutdown kept clear, pin alternating
		for (k = 0; k < 6; k++) begin
			vpin <= k[0];
			for (i = 0; i < 5; i++) begin
				v = 8'($urandom);
				v[5] = (i == 1) ? 1'b0 : v[5];
				wrm(i, v);
			end
			host.wr(8'h10, 8'($urandom));
			for (i = 0; i < 5; i++) rdchk(i);
			settle();
			chk({t_long, 3'h0, lvl}, {mdl[0][7], 3'h0, mdl[0][3:0]});
			chk({en, ph, ff, dly, 2'h0}, {mdl[4][7:2], 2'h0});
			chk(vcode, k[0] ? mdl[3][5:0] : mdl[2][5:0]);
		end
		// Low supply in interrupt mode, enable set then cleared
		wrm(0, 8'h65);
		below <= 1'b1;
		settle();
		rdchk(0);
		chk({s_irq, s_off}, 2'b10);
		wrm(0, 8'h45);
		settle();
		chk(s_irq, 1'b0);
		below <= 1'b0;
		// Fault interrupt gating and power good status
		fault <= 1'b1;
		pg <= 1'b1;
		wrm(4, 8'h82);
		settle();
		chk(f_irq, 1'b1);
		rdchk(4);
		wrm(4, 8'h80);
		settle();
		chk(f_irq, 1'b0);
		fault <= 1'b0;
		// Master shutdown, spare bits lost, pushbutton restarts
		wrm(1, 8'hFF);
		settle();
		chk({s_off, en}, 2'b10);
		mdl[1] = 8'h20;
		rdchk(1);
		pb_n <= 1'b0;
		settle();
		mdl[1] = 8'h00;
		rdchk(1);
		pb_n <= 1'b1;
		settle();
		chk({s_off, en}, 2'b01);
		// Low supply in shutdown mode; spare bits must not survive it
		wrm(1, 8'h0F);
		wrm(0, 8'h03);
		below <= 1'b1;
		settle();
		chk({s_off, en, s_irq}, 3'b100);
		mdl[1] = 8'h00;
		rdchk(1);
		below <= 1'b0;
		pb_n <= 1'b0;
		settle();
		pb_n <= 1'b1;
		settle();
		chk({s_off, en}, 2'b01);
		// Power loss returns every field to default
		uvlo <= 1'b1;
		settle();
		uvlo <= 1'b0;
		settle();
		foreach (mdl[r]) mdl[r] = 8'h00;
		for (i = 0; i < 5; i++) rdchk(i);
		summarize();
	end
endmodule : pmu_system_and_buck_one_regs_tb
